// ===== tsi_defs.vh
// Constants for the touch-sensor serial slave port.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef TSI_DEFS_VH
`define TSI_DEFS_VH
`define TSI_SLAVE_ADDR 7'h12
`define TSI_CLK_MHZ 125
`define TSI_STUCK_MS 14
`define TSI_STUCK_CYC (`TSI_STUCK_MS * 1000 * `TSI_CLK_MHZ)
`define TSI_STRETCH_CYC 4'h8
`define TSI_ADDR_STATUS0 8'h04
`define TSI_ADDR_STATUS1 8'h05
`define TSI_FIFO_DEPTH 16
`define TSI_FIFO_AW 4
`endif

// ===== tsi_fifo.v
// Small synchronous FIFO of flip-flops with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tsi_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire resetn,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge clk) begin
        if (!resetn) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
    always @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ===== tsi_slave.v
// Serial slave port of a touch-sensor device with a byte table behind it.
// Assumes SCL/SDA/strap pins are asynchronous; table is a simple memory port.
//
// Summary of operation
// - Address packet: 7 address, direction, ack.
// - Direction one means read, zero write.
// - Acknowledge own address in ninth period.
// - Bits arrive most significant first.
// - Data packet: eight bits plus ack.
// - Receiver pulls SDA low to acknowledge.
// - SDA changes only while SCL low.
// - Detect start and stop conditions.
// - Bus busy from start until stop.
// - Device may stretch SCL between bytes.
// - Stand-alone mode disables stuck monitor.
// - Byte table with multibyte transfers.
// - Notify low on masked key/input change.
// - Release notify at stop of any read transfer, status bytes read or not.
// - Unchanged-back status: any read releases.
// - Fixed slave address 0x12.
// - Pointer advances one per data byte.
// - Read end restores last sent pointer.
`timescale 1ns/1ps
`default_nettype none
`include "tsi_defs.vh"
module tsi_slave #(
    parameter STUCK_CYC = `TSI_STUCK_CYC
) (
    input wire clk,
    input wire resetn,
    input wire scl_i,
    output reg scl_oe,
    output wire scl_o,
    input wire sda_i,
    output reg sda_oe,
    output wire sda_o,
    input wire standalone,
    output reg change_notify_n_oe,
    output wire change_notify_n_o,
    input wire status_change,
    output reg wr_valid,
    input wire wr_ready,
    output reg [15:0] wr_data,
    output reg [7:0] rd_addr,
    input wire [7:0] rd_data,
    output reg bus_busy
);
    // ************************************************
    // Pin synchronisers and edge detection
    // ************************************************
    localparam S_IDLE = 3'd0;
    localparam S_ADDR = 3'd1;
    localparam S_ACK = 3'd2;
    localparam S_RX = 3'd3;
    localparam S_TX = 3'd4;
    localparam S_MACK = 3'd5;
    localparam S_SKIP = 3'd6;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign change_notify_n_o = 1'b0;
    reg scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    reg sa_m_q, sa_s_q;
    always @(posedge clk) begin
        if (!resetn) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            sa_m_q <= 1'b0;
            sa_s_q <= 1'b0;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            sa_m_q <= standalone;
            sa_s_q <= sa_m_q;
        end
    end
    wire scl_rise = scl_s_q && !scl_p_q;
    wire scl_fall = !scl_s_q && scl_p_q;
    wire start_c = scl_s_q && scl_p_q && !sda_s_q && sda_p_q;
    wire stop_c = scl_s_q && scl_p_q && sda_s_q && !sda_p_q;
    // ************************************************
    // Stuck-line monitor
    // ************************************************
    // A low line that never changes while the other stays put means a
    // lost master; the port restarts rather than hang the bus forever.
    reg [31:0] stuck_q;
    reg port_rst_q;
    wire any_low = !scl_s_q || !sda_s_q;
    wire moved = (scl_s_q != scl_p_q) || (sda_s_q != sda_p_q);
    always @(posedge clk) begin
        if (!resetn) begin
            stuck_q <= 32'h0;
            port_rst_q <= 1'b0;
        end else begin
            port_rst_q <= 1'b0;
            if (sa_s_q || !any_low || moved) begin
                stuck_q <= 32'h0;
            end else if (stuck_q >= STUCK_CYC - 1) begin
                stuck_q <= 32'h0;
                port_rst_q <= 1'b1;
            end else begin
                stuck_q <= stuck_q + 32'h1;
            end
        end
    end
    // ************************************************
    // Byte engine
    // ************************************************
    reg [2:0] st_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg rw_q;
    reg have_ptr_q;
    reg first_q;
    reg [7:0] ptr_q;
    reg [7:0] base_q;
    reg [7:0] tx_q;
    reg [1:0] seen_q;
    reg pend_q;
    reg [3:0] str_q;
    reg push_q;
    reg [15:0] push_data_q;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [15:0] fifo_out_data;
    wire fifo_out_ready = !wr_valid || wr_ready;
    wire fifo_take = fifo_out_valid && fifo_out_ready;
    wire [7:0] sh_next = {sh_q[6:0], sda_s_q};
    always @(posedge clk) begin
        if (!resetn || port_rst_q) begin
            st_q <= S_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            rw_q <= 1'b0;
            have_ptr_q <= 1'b0;
            first_q <= 1'b0;
            ptr_q <= 8'h00;
            base_q <= 8'h00;
            tx_q <= 8'hff;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            str_q <= 4'h0;
            push_q <= 1'b0;
            push_data_q <= 16'h0;
            rd_addr <= 8'h00;
            bus_busy <= 1'b0;
            seen_q <= 2'b00;
            pend_q <= 1'b0;
            change_notify_n_oe <= 1'b0;
        end else begin
            if (push_q && fifo_in_ready) begin
                push_q <= 1'b0;
            end
            rd_addr <= ptr_q;
            // The clock stays held while a word still waits for room.
            if (str_q != 4'h0) begin
                str_q <= str_q - 4'h1;
            end else if (!push_q) begin
                scl_oe <= 1'b0;
            end
            if (start_c) begin
                bus_busy <= 1'b1;
                st_q <= S_ADDR;
                bit_q <= 4'h0;
                sda_oe <= 1'b0;
                seen_q <= 2'b00;
            end else if (stop_c) begin
                bus_busy <= 1'b0;
                st_q <= S_IDLE;
                sda_oe <= 1'b0;
                if (rw_q) begin
                    ptr_q <= base_q;
                end
                rw_q <= 1'b0;
            end else begin
                case (st_q)
                    S_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    S_ADDR, S_RX: begin
                        if (scl_rise) begin
                            sh_q <= sh_next;
                            bit_q <= bit_q + 4'h1;
                        end
                        if (scl_fall && bit_q == 4'h8) begin
                            bit_q <= 4'h0;
                            if (st_q == S_ADDR) begin
                                if (sh_q[7:1] == `TSI_SLAVE_ADDR) begin
                                    rw_q <= sh_q[0];
                                    sda_oe <= 1'b1;
                                    first_q <= 1'b1;
                                    st_q <= S_ACK;
                                end else begin
                                    st_q <= S_SKIP;
                                end
                            end else begin
                                sda_oe <= 1'b1;
                                st_q <= S_ACK;
                                if (!have_ptr_q) begin
                                    have_ptr_q <= 1'b1;
                                    ptr_q <= sh_q;
                                    base_q <= sh_q;
                                end else begin
                                    push_data_q <= {ptr_q, sh_q};
                                    push_q <= 1'b1;
                                    ptr_q <= ptr_q + 8'h1;
                                end
                            end
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            // The count runs down through zero, so one less
                            // keeps the low time at the set figure.
                            str_q <= `TSI_STRETCH_CYC - 4'h1;
                            scl_oe <= 1'b1;
                            if (rw_q) begin
                                sda_oe <= !rd_data[7];
                                tx_q <= {rd_data[6:0], 1'b1};
                                bit_q <= 4'h1;
                                st_q <= S_TX;
                                if (ptr_q == `TSI_ADDR_STATUS0) begin
                                    seen_q[0] <= 1'b1;
                                end
                                if (ptr_q == `TSI_ADDR_STATUS1) begin
                                    seen_q[1] <= 1'b1;
                                end
                                ptr_q <= ptr_q + 8'h1;
                            end else begin
                                if (first_q) begin
                                    have_ptr_q <= 1'b0;
                                end
                                st_q <= S_RX;
                            end
                            first_q <= 1'b0;
                        end
                    end
                    S_TX: begin
                        if (scl_fall) begin
                            if (bit_q == 4'h8) begin
                                sda_oe <= 1'b0;
                                st_q <= S_MACK;
                            end else begin
                                sda_oe <= !tx_q[7];
                                tx_q <= {tx_q[6:0], 1'b1};
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                    end
                    S_MACK: begin
                        if (scl_rise) begin
                            if (sda_s_q) begin
                                st_q <= S_SKIP;
                            end else begin
                                st_q <= S_ACK;
                            end
                        end
                    end
                    S_SKIP: begin
                        sda_oe <= 1'b0;
                    end
                    default: begin
                        st_q <= S_IDLE;
                    end
                endcase
            end
            // Set wins over the release in the same cycle.
            if (status_change) begin
                pend_q <= 1'b1;
                change_notify_n_oe <= 1'b1;
            end else if (stop_c && rw_q && pend_q) begin
                if (seen_q == 2'b11) begin
                    pend_q <= 1'b0;
                    change_notify_n_oe <= 1'b0;
                end else begin
                    change_notify_n_oe <= 1'b0;
                    pend_q <= 1'b0;
                end
            end
        end
    end
    // ************************************************
    // Write buffer and output stage
    // ************************************************
    // The buffer soaks up a slow table side; the bus is stretched further only once it is full.
    tsi_fifo #(
        .WIDTH(16),
        .DEPTH(`TSI_FIFO_DEPTH),
        .AW(`TSI_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(push_q),
        .in_ready(fifo_in_ready),
        .in_data(push_data_q),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );
    // Only the chip reset clears this stage, so a stuck-line restart
    // never drops a word that the table side is already looking at.
    always @(posedge clk) begin
        if (!resetn) begin
            wr_valid <= 1'b0;
            wr_data <= 16'h0;
        end else if (fifo_take) begin
            wr_valid <= 1'b1;
            wr_data <= fifo_out_data;
        end else if (wr_ready) begin
            wr_valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== tsi_slave_props.sv
// Checker for the serial slave port, seeing only its top-level ports.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
`include "tsi_defs.vh"
// ****************
// Port checker
// ****************
module tsi_slave_props #(
    parameter STUCK_CYC = 200
) (
    input wire clk,
    input wire resetn,
    input wire scl_i,
    input wire scl_oe,
    input wire scl_o,
    input wire sda_i,
    input wire sda_oe,
    input wire sda_o,
    input wire standalone,
    input wire change_notify_n_oe,
    input wire change_notify_n_o,
    input wire status_change,
    input wire wr_valid,
    input wire wr_ready,
    input wire [15:0] wr_data,
    input wire [7:0] rd_addr,
    input wire [7:0] rd_data,
    input wire bus_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // A stall on the write side may stretch longer, so it restarts the count.
    logic [7:0] hold_q;
    always @(posedge clk) begin
        if (!resetn || !scl_oe || wr_valid) hold_q <= 8'h00;
        else hold_q <= hold_q + 8'h01;
    end
    busy_on_start_a: assert property (scl_i && $fell(sda_i) |-> ##[1:5] bus_busy)
        else $error("start not seen as busy");
    busy_off_stop_a: assert property (scl_i && $rose(sda_i) |-> ##[1:5] !bus_busy)
        else $error("stop not seen as free");
    idle_sda_a: assert property (!bus_busy |-> !sda_oe)
        else $error("data line driven while bus free");
    sda_scl_low_a: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data line changed while clock high");
    stretch_busy_a: assert property (scl_oe |-> bus_busy)
        else $error("clock held low outside a transfer");
    stretch_len_a: assert property (hold_q <= `TSI_STRETCH_CYC)
        else $error("clock stretch too long");
    wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
        else $error("write word dropped or changed while stalled");
    notify_set_a: assert property (status_change |=> change_notify_n_oe)
        else $error("notify not raised on status change");
    notify_release_a: assert property ($fell(change_notify_n_oe) |-> !bus_busy)
        else $error("notify released inside a transfer");
    cover property (wr_valid && wr_ready);
    cover property ($fell(change_notify_n_oe));
    cover property ($rose(scl_oe));
endmodule
bind tsi_slave tsi_slave_props #(.STUCK_CYC(STUCK_CYC)) u_props (
    .clk(clk), .resetn(resetn), .scl_i(scl_i), .scl_oe(scl_oe),
    .scl_o(scl_o), .sda_i(sda_i), .sda_oe(sda_oe), .sda_o(sda_o),
    .standalone(standalone), .change_notify_n_oe(change_notify_n_oe),
    .change_notify_n_o(change_notify_n_o), .status_change(status_change),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .bus_busy(bus_busy)
);
`default_nettype wire

// ===== tsi_host.sv
// Host bus master model: open-drain pulls on the clock and data lines.
// Assumes the bench resolves the wired lines and feeds them back here.
`timescale 1ns/1ps
`default_nettype none
// ****************
// Host model
// ****************
module tsi_host (
    input wire logic scl,
    input wire logic sda,
    output var logic scl_pull,
    output var logic sda_pull
);
    integer hangs = 0;
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // The slave may stretch, so the clock is only trusted once seen high.
    task wait_high;
        integer n;
        begin
            n = 0;
            while (!scl && n < 4000) begin
                #1;
                n = n + 1;
            end
            if (!scl) hangs = hangs + 1;
        end
    endtask
    task bit_io(input logic b, output logic r);
        begin
            sda_pull = !b;
            #31.25 scl_pull = 1'b0;
            wait_high;
            #31.25 r = sda;
            #31.25 scl_pull = 1'b1;
            #31.25;
        end
    endtask
    task xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
              output logic ack);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                bit_io(tx[i], rx[i]);
            end
            bit_io(ai, ack);
        end
    endtask
    task start;
        begin
            sda_pull = 1'b1;
            #62.5 scl_pull = 1'b1;
            #31.25;
        end
    endtask
    task stop;
        begin
            sda_pull = 1'b1;
            #31.25 scl_pull = 1'b0;
            wait_high;
            #62.5 sda_pull = 1'b0;
            #125;
        end
    endtask
endmodule
`default_nettype wire

// ===== touch_sensor_i2c_slave_port_test.sv
// Self-checking bench for the serial slave port with a host model.
// Assumes the table is read combinationally as pointer xor 0x5a.
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bench top
// ****************
module touch_sensor_i2c_slave_port_test;
    logic clk = 0, resetn = 0, standalone = 0, status_change = 0;
    logic wr_ready = 0;
    logic [3:0] tick = 4'h0;
    wire scl_oe, scl_o, sda_oe, sda_o, cn_oe, cn_o, wr_valid, bus_busy;
    wire scl_pull, sda_pull, scl, sda;
    wire [15:0] wr_data;
    wire [7:0] rd_addr, rd_data;
    integer fails = 0, compares = 0, sda_cnt = 0;
    logic [15:0] wq[$];
    assign scl = !(scl_pull | scl_oe);
    assign sda = !(sda_pull | sda_oe);
    assign rd_data = rd_addr ^ 8'h5a;
    tsi_host u_host (.scl(scl), .sda(sda), .scl_pull(scl_pull),
                     .sda_pull(sda_pull));
    tsi_slave #(.STUCK_CYC(200)) u_dut (
        .clk(clk), .resetn(resetn), .scl_i(scl), .scl_oe(scl_oe),
        .scl_o(scl_o), .sda_i(sda), .sda_oe(sda_oe), .sda_o(sda_o),
        .standalone(standalone), .change_notify_n_oe(cn_oe),
        .change_notify_n_o(cn_o), .status_change(status_change),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .rd_addr(rd_addr), .rd_data(rd_data), .bus_busy(bus_busy));
    initial forever #4 clk = ~clk;
    // The far side stalls half the time to exercise the write handshake.
    always @(negedge clk) begin
        tick <= tick + 4'h1;
        wr_ready <= tick[3];
    end
    always @(posedge clk) begin
        if (wr_valid && wr_ready) wq.push_back(wr_data);
        if (sda_oe) sda_cnt <= sda_cnt + 1;
    end
    task check(input logic [15:0] got, input logic [15:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task summarize;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task sla(input logic [6:0] a, input logic rw, input logic exp_ack);
        logic [7:0] rx;
        logic ack;
        begin
            u_host.start;
            u_host.xfer({a, rw}, 1'b1, rx, ack);
            check(ack, exp_ack);
        end
    endtask
    task t_write(input logic [7:0] ptr, input int n);
        logic [7:0] rx;
        logic ack;
        integer i;
        begin
            wq.delete();
            sla(7'h12, 1'b0, 1'b0);
            check(bus_busy, 1'b1);
            u_host.xfer(ptr, 1'b1, rx, ack);
            for (i = 0; i < n; i = i + 1) begin
                u_host.xfer(8'ha5 + i, 1'b1, rx, ack);
                check(ack, 1'b0);
            end
            u_host.stop;
            check(bus_busy, 1'b0);
            check(16'(wq.size()), 16'(n));
            for (i = 0; i < n; i = i + 1) begin
                check(wq[i], {ptr + 8'(i), 8'ha5 + 8'(i)});
            end
        end
    endtask
    task t_read(input int n, input logic [7:0] base);
        logic [7:0] rx;
        logic ack;
        integer i;
        begin
            sla(7'h12, 1'b1, 1'b0);
            for (i = 0; i < n; i = i + 1) begin
                u_host.xfer(8'hff, i == n - 1, rx, ack);
                check(rx, base + 8'(i) ^ 8'h5a);
            end
            u_host.stop;
            check(rd_addr, base);
        end
    endtask
    task t_other(input logic [6:0] a);
        logic [7:0] rx;
        logic ack;
        integer c0;
        begin
            c0 = sda_cnt;
            sla(a, 1'b0, 1'b1);
            u_host.xfer(8'h00, 1'b1, rx, ack);
            u_host.stop;
            check(16'(sda_cnt - c0), 16'h0000);
        end
    endtask
    task pulse;
        begin
            @(negedge clk) status_change = 1'b1;
            @(negedge clk) status_change = 1'b0;
            @(negedge clk) check(cn_oe, 1'b1);
        end
    endtask
    task t_notify;
        begin
            pulse;
            t_write(8'h04, 0);
            check(cn_oe, 1'b1);
            t_read(2, 8'h04);
            check(cn_oe, 1'b0);
            pulse;
            pulse;
            t_read(1, 8'h04);
            check(cn_oe, 1'b0);
        end
    endtask
    task t_stuck(input logic sa, input logic exp_busy);
        begin
            @(negedge clk) standalone = sa;
            u_host.start;
            #2400;
            check(bus_busy, exp_busy);
            u_host.stop;
            check(bus_busy, 1'b0);
            @(negedge clk) standalone = 1'b0;
        end
    endtask
    initial begin
        #720000;
        fails = fails + 1;
        summarize;
    end
    initial begin
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        check({bus_busy, sda_oe, scl_oe, cn_oe}, 16'h0000);
        t_write(8'h20, 3);
        t_write(8'h20, 0);
        t_read(3, 8'h20);
        t_read(1, 8'h20);
        t_other(7'h13);
        t_other(7'h52);
        t_notify;
        t_stuck(1'b0, 1'b0);
        t_stuck(1'b1, 1'b1);
        check(16'(u_host.hangs), 16'h0000);
        summarize;
    end
endmodule
`default_nettype wire
